// ### cgl_params.svh
/*
 * constants of the mode and configuration loader: slave addresses, control
 * register layout, power-down field positions and timing counts.
 * assumes the includer has no macros of the same names.
 */
`ifndef CGL_PARAMS_SVH
`define CGL_PARAMS_SVH

// serial slave addresses: control seven bits, eeprom upper four bits
`define CGL_CTRL_ADDR      7'h5C
`define CGL_EE_ADDR_HI     4'hA

// control register array: 16 bytes, pointer wraps after the last
`define CGL_NUM_REGS       16
`define CGL_PTR_W          4

// power-down enable field positions inside one control byte
`define CGL_PD_BYTE        4'hF
`define CGL_PLL_PD_LSB     0
`define CGL_POST_PD_LSB    3

// timing: system clock rate, self-load length, eeprom commit time
`define CGL_SYS_CLK_MHZ    40
`define CGL_LOAD_CYCLES    89000
`define CGL_EE_WRITE_US    4000
`define CGL_EE_WRITE_CYCLES (`CGL_EE_WRITE_US * `CGL_SYS_CLK_MHZ)

`endif

// ### cgl_pkg.sv
/*
 * types of the mode and configuration loader: serial slave states and the
 * bundle of output controls handed to the clock path.
 * assumes cgl_params.svh is compiled alongside.
 */
package cgl_pkg;

   // serial slave states, gray along idle-rx-ack-tx-mack
   typedef enum logic [2:0] {
      CGL_IDLE = 3'h0,
      CGL_RX   = 3'h1,
      CGL_ACK  = 3'h3,
      CGL_TX   = 3'h2,
      CGL_MACK = 3'h6
   } cgl_state_t;

   // controls for plls, post dividers, drivers and oscillator
   typedef struct packed {
      logic [2:0] pll_pd;
      logic [3:0] post_pd;
      logic [3:0] force_low;
      logic [3:0] out_oe;
      logic       osc_pd;
      logic       xin_force_low;
      logic       crystal_out_pin_pull_high;
      logic       hold_low;
      logic       ref_bypass;
      logic       second_set;
   } cgl_out_ctl_t;

endpackage

// ### cgl_loader.sv
/*
 * mode and configuration loader of a three-pll clock generator: mode latch,
 * eeprom self-load, run-mode power-down and output enable, and a serial
 * slave with an eeprom and a control-register target.
 * assumes i_sys_clk is the crystal reference, pull-ups sit on the pads, and
 * the serial clock pad also clocks the receive shift register.
 */
// Notes on behaviour
// - mode pin low gives program mode, high gives run mode; pad pull-up defaults run
// - a high mode level is latched; one eeprom transfer per power cycle
// - run mode uses shared pins as power-down and enable; program mode as serial bus
// - in program mode registers may be rewritten at any time, eeprom whenever no commit is busy
// - pair select pin low picks first c/d settings, high picks second
// - entering run mode copies eeprom over 89000 clocks, outputs held low meanwhile
// - all-zero loaded contents route the crystal reference to all outputs
// - power-down input high powers down only sections whose enable bits are set
// - a powered-down post divider forces its output driver low
// - all plls and post dividers down also stops oscillator, xin low, crystal_out_pin high
// - output enable input low puts all clock outputs in high impedance
// - entering program mode clears all control registers to zero
// - eeprom and control registers are two slaves chosen by device address
// - eeprom answers 1010 with three don't-care low address bits
// - control registers answer 1011100, random and sequential, take effect at once
// - eeprom writes are single-byte random writes only
// - after stop eeprom commits for 4 ms and acknowledges nothing meanwhile
// - stop before a complete eeprom write aborts it, memory unchanged
// - surplus data bytes discard the loaded byte and refill the buffer
// - eeprom reads random and sequential, pointer advances per byte
// - random write: address, register pointer, one data byte, each acknowledged
// - random read: set pointer, repeated start, read one byte, no master ack, stop
// - sequential register writes wrap after 16 bytes, each updates at its ack
// - stop or repeated start mid-write discards the partial register data
`timescale 1ns/100ps
`include "cgl_params.svh"

module cgl_loader #(
   parameter int LOAD_CYCLES     = `CGL_LOAD_CYCLES,
   parameter int EE_WRITE_CYCLES = `CGL_EE_WRITE_CYCLES
) (
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_rstn,
   input  wire logic                    i_mode_pin,
   input  wire logic                    i_output_pair_select,
   input  wire logic                    i_powerdown_or_serial_clock_pin,
   input  wire logic                    i_oe_or_serial_data_pin,
   output logic                         o_oe_or_serial_data_out,
   output logic                         o_oe_or_serial_data_oe,
   output logic [8*`CGL_NUM_REGS-1:0]   o_ctrl_regs,
   output cgl_pkg::cgl_out_ctl_t        o_out_ctl
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [2:0]               mode_sync;
   logic [2:0]               sel_sync;
   logic [2:0]               scl_sync;
   logic [2:0]               sda_sync;
   logic                     run_latch;
   logic                     load_done;
   logic [16:0]              load_cnt;
   logic                     prog;
   logic                     prog_d;
   logic                     scl_rise;
   logic                     scl_fall;
   logic                     bus_start;
   logic                     bus_stop;
   logic [7:0]               link_shift;
   logic [7:0]               rx_byte;
   cgl_pkg::cgl_state_t      state;
   logic [3:0]               bit_cnt;
   logic [1:0]               byte_idx;
   logic                     rw_read;
   logic                     tgt_ee;
   logic                     ack_bit;
   logic                     mack_ok;
   logic [7:0]               tx_shift;
   logic [`CGL_PTR_W-1:0]    ctl_ptr;
   logic [`CGL_PTR_W-1:0]    ee_ptr;
   logic [7:0]               ctrl [`CGL_NUM_REGS];
   logic [7:0]               eeprom [`CGL_NUM_REGS];
   logic [7:0]               ee_buf;
   logic                     ee_buf_ok;
   logic                     ee_busy;
   logic [17:0]              ee_cnt;
   logic                     addr_ctl;
   logic                     addr_ee;
   logic                     rx_done;
   logic                     ack_end;
   logic                     ee_commit;
   logic [7:0]               pd_byte;
   logic                     pd_req;
   logic [2:0]               next_pll_pd;
   logic [3:0]               next_post_pd;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only stage 1 and later feed logic

   // two flops per pad, a third stage gives the edge history
   always_ff @(posedge i_sys_clk) begin
      mode_sync <= {mode_sync[1:0], i_mode_pin};
      sel_sync  <= {sel_sync[1:0], i_output_pair_select};
      scl_sync  <= {scl_sync[1:0], i_powerdown_or_serial_clock_pin};
      sda_sync  <= {sda_sync[1:0], i_oe_or_serial_data_pin};
   end

   assign scl_rise  = scl_sync[1] & ~scl_sync[2];
   assign scl_fall  = ~scl_sync[1] & scl_sync[2];
   // data edge while clock stays high marks start or stop
   assign bus_start = prog & scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
   assign bus_stop  = prog & scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // link domain: serial clock captures data, msb first

   // the byte is read by the system side only after the eighth fall; it stays
   // still until the ninth rise, which falls inside the acknowledge bit
   always_ff @(posedge i_powerdown_or_serial_clock_pin) begin
      link_shift <= {link_shift[6:0], i_oe_or_serial_data_pin};
   end

   assign rx_byte = link_shift;

   ////////////////////////////////////////////////////////////////////////////
   // mode latch and self-load

   // once high the run latch stays until power-on reset
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         run_latch <= 1'b0;
      end else if (mode_sync[1]) begin
         run_latch <= 1'b1;
      end
   end

   assign prog = ~run_latch & ~mode_sync[1];

   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         prog_d <= 1'b0;
      end else begin
         prog_d <= prog;
      end
   end

   // self-load length counter; done never falls again before reset
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         load_cnt  <= 17'h00000;
         load_done <= 1'b0;
      end else if (run_latch && !load_done) begin
         load_cnt <= load_cnt + 17'h00001;
         if (load_cnt == 17'(LOAD_CYCLES - 1)) begin
            load_done <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial slave state machine

   assign addr_ctl  = (rx_byte[7:1] == `CGL_CTRL_ADDR);
   assign addr_ee   = (rx_byte[7:4] == `CGL_EE_ADDR_HI) && !ee_busy;
   assign rx_done   = (state == cgl_pkg::CGL_RX) && scl_fall && (bit_cnt == 4'h8);
   assign ack_end   = (state == cgl_pkg::CGL_ACK) && scl_fall;
   assign ee_commit = ee_busy && (ee_cnt == 18'(EE_WRITE_CYCLES - 1));

   // start from any state restarts address reception; stop or leaving program
   // mode drops the slave back to idle
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn || !prog) begin
         state    <= cgl_pkg::CGL_IDLE;
         bit_cnt  <= 4'h0;
         byte_idx <= 2'h0;
         rw_read  <= 1'b0;
         tgt_ee   <= 1'b0;
         ack_bit  <= 1'b0;
         mack_ok  <= 1'b0;
         tx_shift <= 8'h00;
      end else if (bus_start) begin
         state    <= cgl_pkg::CGL_RX;
         bit_cnt  <= 4'h0;
         byte_idx <= 2'h0;
      end else if (bus_stop) begin
         state <= cgl_pkg::CGL_IDLE;
      end else begin
         unique case (state)
            cgl_pkg::CGL_IDLE: begin
               bit_cnt <= 4'h0;
            end
            cgl_pkg::CGL_RX: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (rx_done) begin
                  state <= cgl_pkg::CGL_ACK;
                  if (byte_idx == 2'h0) begin
                     rw_read <= rx_byte[0];
                     tgt_ee  <= ~addr_ctl;
                     ack_bit <= addr_ctl | addr_ee;
                  end else begin
                     ack_bit <= 1'b1;
                  end
               end
            end
            cgl_pkg::CGL_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (!ack_bit) begin
                     state <= cgl_pkg::CGL_IDLE;
                  end else if (rw_read) begin
                     state    <= cgl_pkg::CGL_TX;
                     tx_shift <= tgt_ee ? eeprom[ee_ptr] : ctrl[ctl_ptr];
                  end else begin
                     state <= cgl_pkg::CGL_RX;
                     if (byte_idx != 2'h2) begin
                        byte_idx <= byte_idx + 2'h1;
                     end
                  end
               end
            end
            cgl_pkg::CGL_TX: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     state <= cgl_pkg::CGL_MACK;
                  end else begin
                     tx_shift <= {tx_shift[6:0], 1'b0};
                  end
               end
            end
            cgl_pkg::CGL_MACK: begin
               // a missing master acknowledge ends the read
               if (scl_rise) begin
                  mack_ok <= ~sda_sync[1];
               end else if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (mack_ok) begin
                     state    <= cgl_pkg::CGL_TX;
                     tx_shift <= tgt_ee ? eeprom[ee_ptr] : ctrl[ctl_ptr];
                  end else begin
                     state <= cgl_pkg::CGL_IDLE;
                  end
               end
            end
            default: begin
               state <= cgl_pkg::CGL_IDLE;
            end
         endcase
      end
   end

   // data pin is open drain: only ever pulled low
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn || !prog) begin
         o_oe_or_serial_data_oe <= 1'b0;
      end else if (state == cgl_pkg::CGL_ACK) begin
         o_oe_or_serial_data_oe <= ack_bit;
      end else if (state == cgl_pkg::CGL_TX) begin
         o_oe_or_serial_data_oe <= ~tx_shift[7];
      end else begin
         o_oe_or_serial_data_oe <= 1'b0;
      end
   end

   assign o_oe_or_serial_data_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // pointers

   // the pointer byte loads the selected slave's pointer; each read byte or
   // register write advances it, wrapping after sixteen
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ctl_ptr <= '0;
         ee_ptr  <= '0;
      end else if (rx_done && byte_idx == 2'h1) begin
         if (tgt_ee) begin
            ee_ptr <= rx_byte[`CGL_PTR_W-1:0];
         end else begin
            ctl_ptr <= rx_byte[`CGL_PTR_W-1:0];
         end
      end else if (ack_end && rw_read && ack_bit && byte_idx != 2'h0) begin
         // unreachable for reads; kept pointer unchanged here
         ctl_ptr <= ctl_ptr;
      end else if ((state == cgl_pkg::CGL_ACK && scl_fall && ack_bit && rw_read) ||
                   (state == cgl_pkg::CGL_MACK && scl_fall && mack_ok)) begin
         if (tgt_ee) begin
            ee_ptr <= ee_ptr + 1'b1;
         end else begin
            ctl_ptr <= ctl_ptr + 1'b1;
         end
      end else if (rx_done && byte_idx == 2'h2 && !tgt_ee) begin
         ctl_ptr <= ctl_ptr + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   // cleared at reset and on program entry, filled by the self-load, and
   // written byte by byte as each acknowledge starts
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn || (prog && !prog_d)) begin
         for (int i = 0; i < `CGL_NUM_REGS; i++) begin
            ctrl[i] <= 8'h00;
         end
      end else if (run_latch && !load_done && load_cnt == 17'h00000) begin
         for (int i = 0; i < `CGL_NUM_REGS; i++) begin
            ctrl[i] <= eeprom[i];
         end
      end else if (rx_done && byte_idx == 2'h2 && !tgt_ee && !rw_read) begin
         ctrl[ctl_ptr] <= rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // eeprom write buffer and timed commit

   // a later data byte overwrites the buffer; start or stop without a full
   // byte leaves nothing to commit
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn || !prog) begin
         ee_buf    <= 8'h00;
         ee_buf_ok <= 1'b0;
      end else if (bus_start || bus_stop) begin
         ee_buf_ok <= 1'b0;
      end else if (rx_done && byte_idx == 2'h2 && tgt_ee && !rw_read) begin
         ee_buf    <= rx_byte;
         ee_buf_ok <= 1'b1;
      end
   end

   // busy window during which the eeprom address is not acknowledged
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ee_busy <= 1'b0;
         ee_cnt  <= 18'h00000;
      end else if (ee_busy) begin
         ee_cnt <= ee_cnt + 18'h00001;
         if (ee_commit) begin
            ee_busy <= 1'b0;
         end
      end else if (bus_stop && ee_buf_ok) begin
         ee_busy <= 1'b1;
         ee_cnt  <= 18'h00000;
      end
   end

   // storage is flip-flops; reset zero stands in for an erased array
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         for (int i = 0; i < `CGL_NUM_REGS; i++) begin
            eeprom[i] <= 8'h00;
         end
      end else if (ee_commit) begin
         eeprom[ee_ptr] <= ee_buf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run-mode output controls

   assign pd_byte = ctrl[`CGL_PD_BYTE];
   assign pd_req  = run_latch & load_done & scl_sync[1];

   // only sections with their enable bit set follow the power-down input
   always_comb begin
      next_pll_pd  = pd_req ? pd_byte[`CGL_PLL_PD_LSB +: 3] : 3'h0;
      next_post_pd = pd_req ? pd_byte[`CGL_POST_PD_LSB +: 4] : 4'h0;
   end

   // registered so the clock path sees no decode glitches
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_out_ctl <= '0;
      end else begin
         o_out_ctl.pll_pd         <= next_pll_pd;
         o_out_ctl.post_pd        <= next_post_pd;
         o_out_ctl.hold_low       <= run_latch & ~load_done;
         o_out_ctl.force_low      <= next_post_pd | {4{run_latch & ~load_done}};
         o_out_ctl.osc_pd         <= (&next_pll_pd) & (&next_post_pd);
         o_out_ctl.xin_force_low  <= (&next_pll_pd) & (&next_post_pd);
         o_out_ctl.crystal_out_pin_pull_high <= (&next_pll_pd) & (&next_post_pd);
         o_out_ctl.out_oe         <= {4{~run_latch | sda_sync[1]}};
         o_out_ctl.ref_bypass     <= (o_ctrl_regs == '0);
         o_out_ctl.second_set     <= sel_sync[1];
      end
   end

   // flatten the register array, byte 0 lowest
   always_comb begin
      for (int i = 0; i < `CGL_NUM_REGS; i++) begin
         o_ctrl_regs[8*i +: 8] = ctrl[i];
      end
   end

endmodule // cgl_loader

// ### cgl_loader_asserts.sv
/* port checks of the mode and configuration loader.
   assumes one system clock domain. */
`timescale 1ns/100ps
`include "cgl_params.svh"

module cgl_loader_asserts #(
   parameter int LOAD_CYCLES = `CGL_LOAD_CYCLES
) (
   input logic                        i_sys_clk,
   input logic                        i_rstn,
   input logic                        i_mode_pin,
   input logic                        i_output_pair_select,
   input logic                        i_powerdown_or_serial_clock_pin,
   input logic                        i_oe_or_serial_data_pin,
   input logic                        o_oe_or_serial_data_out,
   input logic                        o_oe_or_serial_data_oe,
   input logic [8*`CGL_NUM_REGS-1:0]  o_ctrl_regs,
   input cgl_pkg::cgl_out_ctl_t       o_out_ctl
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   int         up;
   int         cnt;
   logic       run_h;
   logic       steady;
   logic [7:0] pd_en;

   ////////////////////////////////////////////////////////////
   // cycles since reset and since the sticky run request; margins cover pin sync
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         up    <= 0;
         cnt   <= 0;
         run_h <= 1'b0;
      end else begin
         if (up < 15) up <= up + 1;
         if (i_mode_pin) run_h <= 1'b1;
         if (run_h && cnt < LOAD_CYCLES + 64) cnt <= cnt + 1;
      end
   end

   assign steady = (cnt >= LOAD_CYCLES + 12);
   assign pd_en  = o_ctrl_regs[127:120];

   ////////////////////////////////////////////////////////////
   chk_reset_clears: assert property (disable iff (1'b0)
      !i_rstn |=> o_ctrl_regs == '0 && o_out_ctl == '0 && !o_oe_or_serial_data_oe)
      else $error("no reset clear");
   chk_data_open_drain: assert property (o_oe_or_serial_data_out == 1'b0)
      else $error("data driven high");
   chk_run_no_ack: assert property (run_h && cnt >= 4 |-> !o_oe_or_serial_data_oe)
      else $error("answer in run mode");
   chk_empty_bypass: assert property (
      up >= 4 && o_ctrl_regs == '0 && $past(o_ctrl_regs) == '0 |-> o_out_ctl.ref_bypass)
      else $error("no bypass");
   chk_load_hold: assert property (
      run_h && cnt >= 6 && cnt <= LOAD_CYCLES |-> o_out_ctl.hold_low && o_out_ctl.force_low == 4'hF)
      else $error("no hold in load");
   chk_load_release: assert property (steady |-> !o_out_ctl.hold_low)
      else $error("hold after load");
   chk_pd_apply: assert property (
      (steady && i_powerdown_or_serial_clock_pin) [*5] |-> o_out_ctl.pll_pd == pd_en[2:0]
      && o_out_ctl.post_pd == pd_en[6:3] && o_out_ctl.force_low == pd_en[6:3])
      else $error("bad power-down");
   chk_osc_stop: assert property (
      (steady && i_powerdown_or_serial_clock_pin && pd_en[6:0] == 7'h7F) [*5]
      |-> o_out_ctl.osc_pd && o_out_ctl.xin_force_low && o_out_ctl.crystal_out_pin_pull_high)
      else $error("oscillator runs");
   chk_oe_tristate: assert property (
      (steady && !i_oe_or_serial_data_pin) [*5] |-> o_out_ctl.out_oe == 4'h0)
      else $error("outputs enabled");
   chk_pair_select: assert property (
      (up >= 8 && $stable(i_output_pair_select)) [*5] |-> o_out_ctl.second_set == i_output_pair_select)
      else $error("bad set select");

   cover property (run_h && o_out_ctl.hold_low);
   cover property (steady && o_out_ctl.osc_pd);
   cover property (o_oe_or_serial_data_oe);
endmodule // cgl_loader_asserts

// ### cgl_host_model.sv
/* serial bus master standing in for the programming host.
   assumes the bench resolves the open-drain data line with a pull-up. */
`timescale 1ns/100ps

module cgl_host_model (
   input  wire logic i_link_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   // bus idle: clock stands high between frames
   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // one phase, long against the pin sync
   task automatic step(input logic c, input logic dl);
      o_scl     <= c;
      o_sda_low <= dl;
      repeat (16) @(posedge i_link_clk);
   endtask

   // data falls while clock high; works as repeated start too
   task automatic start();
      step(o_scl, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask

   // data rises while clock high
   task automatic stop();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask

   // data changes only while clock low; sampled at end of high
   task automatic clk_bit(input logic b, output logic r);
      step(1'b0, !b);
      step(1'b1, !b);
      r = i_sda;
      step(1'b0, !b);
   endtask

   // eight bits then the acknowledge bit; last=1 releases the line
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
      clk_bit(last, ack);
   endtask
endmodule // cgl_host_model

// ### cgl_loader_tb.sv
/* self-checking bench of the mode and configuration loader.
   assumes the host model and checker are compiled with it. */
`timescale 1ns/100ps
`include "cgl_params.svh"

module cgl_loader_tb;
   localparam int         LOAD = 20;
   localparam int         EEW  = 400;
   localparam logic [6:0] CTRL = `CGL_CTRL_ADDR;

   logic         clk  = 1'b0;
   logic         lclk = 1'b0;
   logic         rstn = 1'b0;
   logic         mode = 1'b0;
   logic         sel  = 1'b0;
   logic         pd   = 1'b0;
   logic         oe   = 1'b1;
   logic         ser  = 1'b1;
   logic         scl, sda_low, dev_oe, dev_out, k;
   logic [127:0] ctl;
   logic [7:0]   wd [4];
   logic [7:0]   rdv [4];
   logic [7:0]   ee [16];
   logic [7:0]   rx;
   logic [6:0]   ea;
   int           n_fail = 0;
   int           comparisons = 0;
   int           polls;

   cgl_pkg::cgl_out_ctl_t oc;

   ////////////////////////////////////////////////////////////
   // system clock 25 ns; link clock 12 ns, offset in phase
   always #12.5 clk = ~clk;
   initial begin
      #3.3;
      forever #6 lclk = ~lclk;
   end

   cgl_loader #(.LOAD_CYCLES(LOAD), .EE_WRITE_CYCLES(EEW)) cgl_loader_i (
      .i_sys_clk(clk), .i_rstn(rstn), .i_mode_pin(mode), .i_output_pair_select(sel),
      .i_powerdown_or_serial_clock_pin(ser ? scl : pd),
      .i_oe_or_serial_data_pin(ser ? !(sda_low || dev_oe) : oe),
      .o_oe_or_serial_data_out(dev_out), .o_oe_or_serial_data_oe(dev_oe),
      .o_ctrl_regs(ctl), .o_out_ctl(oc));
   cgl_host_model cgl_host_model_i (.i_link_clk(lclk), .i_sda(ser ? !(sda_low || dev_oe) : oe),
      .o_scl(scl), .o_sda_low(sda_low));

   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // write frame: address (ack in k), pointer, n bytes, stop if s
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n, input logic s);
      logic a2;
      cgl_host_model_i.start();
      cgl_host_model_i.xfer({a, 1'b0}, 1'b1, rx, k);
      cgl_host_model_i.xfer(p, 1'b1, rx, a2);
      for (int i = 0; i < n; i++) cgl_host_model_i.xfer(wd[i], 1'b1, rx, a2);
      if (s) cgl_host_model_i.stop();
   endtask

   // pointer set, repeated start, n bytes, last without master ack
   task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n);
      logic a2;
      wr(a, p, 0, 1'b0);
      cgl_host_model_i.start();
      cgl_host_model_i.xfer({a, 1'b1}, 1'b1, rx, a2);
      for (int i = 0; i < n; i++) cgl_host_model_i.xfer(8'hFF, i == n - 1, rdv[i], a2);
      cgl_host_model_i.stop();
   endtask

   // address the eeprom until it answers, then stop
   task automatic poll();
      polls = 0;
      do begin
         if (polls > 0) cgl_host_model_i.stop();
         cgl_host_model_i.start();
         cgl_host_model_i.xfer({ea, 1'b0}, 1'b1, rx, k);
         polls++;
      end while (k !== 1'b0 && polls < 40);
      cgl_host_model_i.stop();
   endtask

   function automatic logic [127:0] img();
      for (int i = 0; i < 16; i++) img[8*i +: 8] = ee[i];
   endfunction

   // hang guard, well beyond the expected run
   initial begin
      #2000000;
      n_fail++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h0E18));
      for (int i = 0; i < 16; i++) ee[i] = 8'h00;
      cyc(20);
      rstn <= 1'b1;
      cyc(4);
      chk(ctl, 128'h0);
      chk({oc.ref_bypass, oc.out_oe}, 5'h1F);
      // sequential control write from 14 wraps to register 0
      for (int i = 0; i < 3; i++) wd[i] = 8'($urandom);
      wr(CTRL, 8'h0E, 3, 1'b1);
      chk(k, 1'b0);
      chk({ctl[7:0], ctl[127:112]}, {wd[2], wd[1], wd[0]});
      rd(CTRL, 8'h0F, 1);
      chk(rdv[0], wd[1]);
      // data cut short by a stop leaves register 1 alone
      wd[0] = 8'($urandom) | 8'h80;
      wr(CTRL, 8'h01, 0, 1'b0);
      for (int j = 7; j >= 4; j--) cgl_host_model_i.clk_bit(wd[0][j], k);
      cgl_host_model_i.stop();
      chk(ctl[15:8], 8'h00);
      // eeprom: one byte, busy while committing, then two bytes
      ea = {`CGL_EE_ADDR_HI, 3'($urandom)};
      wd[0] = 8'($urandom);
      wr(ea, 8'h02, 1, 1'b1);
      chk(k, 1'b0);
      ee[2] = wd[0];
      poll();
      chk({polls > 1, k}, 2'h2);
      wd[0] = 8'($urandom);
      wd[1] = 8'($urandom);
      wr(ea, 8'h03, 2, 1'b1);
      ee[3] = wd[1];
      poll();
      // aborted write commits nothing
      wr(ea, 8'h04, 0, 1'b0);
      for (int j = 0; j < 4; j++) cgl_host_model_i.clk_bit(1'($urandom), rx[0]);
      cgl_host_model_i.stop();
      wd[0] = 8'h7F;
      wr(ea, 8'h0F, 1, 1'b1);
      chk(k, 1'b0);
      ee[15] = 8'h7F;
      poll();
      // address of neither slave gets no answer
      cgl_host_model_i.start();
      cgl_host_model_i.xfer(8'h60, 1'b1, rx, k);
      cgl_host_model_i.stop();
      chk(k, 1'b1);
      rd(ea, 8'h02, 3);
      chk({rdv[0], rdv[1], rdv[2]}, {ee[2], ee[3], ee[4]});
      chk(ctl[31:16], 16'h0);
      for (int i = 0; i < 4; i++) begin
         cyc(1);
         sel <= 1'(i % 2);
         cyc(6);
         chk(oc.second_set, sel);
      end
      // run mode: image copied, pins act
      cyc(1);
      ser  <= 1'b0;
      mode <= 1'b1;
      cyc(LOAD + 30);
      chk(ctl, img());
      chk(oc.ref_bypass, 1'b0);
      pd <= 1'b1;
      cyc(6);
      chk({oc.pll_pd, oc.post_pd, oc.force_low}, 11'h7FF);
      chk({oc.osc_pd, oc.xin_force_low, oc.crystal_out_pin_pull_high}, 3'h7);
      pd <= 1'b0;
      oe <= 1'b0;
      cyc(6);
      chk({oc.pll_pd, oc.post_pd, oc.out_oe}, 11'h000);
      oe   <= 1'b1;
      mode <= 1'b0;
      ser  <= 1'b1;
      cyc(10);
      wd[0] = 8'($urandom);
      wr(CTRL, 8'h00, 1, 1'b1);
      chk(k, 1'b1);
      chk(ctl, img());
      // power cycle re-arms the load
      cyc(1);
      ser  <= 1'b0;
      mode <= 1'b1;
      rstn <= 1'b0;
      cyc(20);
      rstn <= 1'b1;
      cyc(LOAD / 2);
      chk(oc.hold_low, 1'b1);
      cyc(LOAD + 30);
      chk({ctl, oc.ref_bypass}, {128'h0, 1'b1});
      end_of_test();
   end
endmodule // cgl_loader_tb

bind cgl_loader cgl_loader_asserts #(.LOAD_CYCLES(LOAD_CYCLES)) cgl_loader_asserts_i (.*);
